// ### exc_cause_pkg.sv
// Constants shared by the exception cause status logic
package exc_cause_pkg;

  // ----------------------------------------------------------------
  // Field positions in the cause word
  // ----------------------------------------------------------------
  localparam int DELAY_SLOT_POS = 31;
  localparam int TIMER_POS      = 30;
  localparam int COP_HI_POS     = 29;
  localparam int COP_LO_POS     = 28;
  localparam int STOP_POS       = 27;
  localparam int PERF_POS       = 26;
  localparam int CHAIN_POS      = 25;
  localparam int PROLOGUE_POS   = 24;
  localparam int VSEL_POS       = 23;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int COP_W  = 2;
  localparam int VOFS_W = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic                STOP_RESET     = 1'h0;
  localparam logic                VSEL_RESET     = 1'h0;
  localparam logic                PERF_RESET     = 1'h0;
  localparam logic                TIMER_RESET    = 1'h0;
  localparam logic                CHAIN_RESET    = 1'h0;
  localparam logic                SLOT_RESET     = 1'h0;
  localparam logic                PROLOGUE_RESET = 1'h0;
  localparam logic [COP_W-1:0]    COP_RESET      = 2'h0;
  localparam logic [ADDR_W-1:0]   RET_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0]         RDATA_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Interrupt vector offsets
  // ----------------------------------------------------------------
  localparam logic [VOFS_W-1:0] GENERAL_VECTOR_OFFSET   = 12'h180;
  localparam logic [VOFS_W-1:0] INTERRUPT_VECTOR_OFFSET = 12'h200;

endpackage : exc_cause_pkg

// ### exc_event_if.sv
// Exception event carrier between the cause block and its capture unit
`timescale 1ns/1ns
`default_nettype none

interface exc_event_if;
  import exc_cause_pkg::*;

  logic              taken;       // One-cycle exception entry pulse
  logic              in_slot;     // Faulting instr in delay/forbidden slot
  logic              in_prologue; // Exception during auto-prologue
  logic              exc_level;   // Exception level before this exception
  logic [ADDR_W-1:0] fault_pc;    // Address of faulting instruction
  logic [ADDR_W-1:0] branch_pc;   // Address of preceding branch
  logic [COP_W-1:0]  cop_unit;    // Referenced coprocessor number

  modport source  (output taken, in_slot, in_prologue, exc_level,
                   output fault_pc, branch_pc, cop_unit);
  modport capture (input  taken, in_slot, in_prologue, exc_level,
                   input  fault_pc, branch_pc, cop_unit);
endinterface : exc_event_if

`default_nettype wire

// ### exc_capture.sv
// Capture of exception-time fields and return address
`timescale 1ns/1ns
`default_nettype none

module exc_capture
  import exc_cause_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  exc_event_if.capture           ev,
  output var  logic              delay_slot_flag_out,
  output var  logic              prologue_flag_out,
  output var  logic [COP_W-1:0]  cop_unit_out,
  output var  logic [ADDR_W-1:0] return_address_out
);

  // ----------------------------------------------------------------
  // Update decode
  // ----------------------------------------------------------------
  // Slot flag and return address move only on entry at level zero
  wire               first_level   = ev.taken & ~ev.exc_level;
  wire [ADDR_W-1:0]  next_ret_addr = ev.in_slot ? ev.branch_pc
                                                : ev.fault_pc;

  // Slot flag and return address
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      delay_slot_flag_out <= SLOT_RESET;
      return_address_out  <= RET_ADDR_RESET;
    end else if (first_level) begin
      delay_slot_flag_out <= ev.in_slot;
      return_address_out  <= next_ret_addr;
    end
  end

  // Fields loaded on every exception
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cop_unit_out      <= COP_RESET;
      prologue_flag_out <= PROLOGUE_RESET;
    end else if (ev.taken) begin
      cop_unit_out      <= ev.cop_unit;
      prologue_flag_out <= ev.in_prologue;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SLOT_SET: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    first_level |=> delay_slot_flag_out == $past(ev.in_slot))
    else $error("slot flag not captured");

  AST_SLOT_HOLD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    (ev.taken && ev.exc_level) |=> $stable(delay_slot_flag_out)
                                   && $stable(return_address_out))
    else $error("slot flag or return address changed at raised level");

  AST_RET_BRANCH: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    (first_level && ev.in_slot) |=>
      return_address_out == $past(ev.branch_pc))
    else $error("return address not branch address");

  AST_COP_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    ev.taken |=> cop_unit_out == $past(ev.cop_unit))
    else $error("coprocessor number not loaded");

  AST_PROLOGUE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    ev.taken |=> prologue_flag_out == $past(ev.in_prologue))
    else $error("prologue flag wrong");

  COV_SLOT_EXC: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) first_level && ev.in_slot);

endmodule : exc_capture

`default_nettype wire

// ### exc_cause_status.sv
// Upper fields of the exception cause register
//
// Operation
// - Exception at level zero records whether the fault sat in a slot.
// - Slot faults at level zero load the return address with the preceding branch.
// - Bit 30 reads the pending timer interrupt, read only.
// - Timer pending flag also drives a dedicated output.
// - Bits 29:28 load the referenced coprocessor on every exception.
// - Bit 27 read-write, reset 0; set stops the cycle counter.
// - Bit 26 reads pending counter interrupt, reset 0, also output.
// - Bit 25 shows whether the last interrupt return chained.
// - Bit 23 is writable and selects the interrupt vector.
// - Select 0 gives offset 0x180, select 1 gives offset 0x200.
`timescale 1ns/1ns
`default_nettype none

module exc_cause_status
  import exc_cause_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              reset_n_in,
  // Register access port
  input  wire logic              reg_write_in,
  input  wire logic [31:0]       reg_wdata_in,
  output var  logic [31:0]       reg_rdata_out,
  // Exception pipeline
  input  wire logic              exc_taken_in,
  input  wire logic              exc_in_slot_in,
  input  wire logic              exc_in_prologue_in,
  input  wire logic              exception_level_bit_in,
  input  wire logic [ADDR_W-1:0] exc_fault_pc_in,
  input  wire logic [ADDR_W-1:0] exc_branch_pc_in,
  input  wire logic [COP_W-1:0]  exc_cop_unit_in,
  // Interrupt return
  input  wire logic              int_return_done_in,
  input  wire logic              int_return_chained_in,
  // Pending interrupt sources
  input  wire logic              timer_irq_in,
  input  wire logic              perf_irq_in,
  // Outputs to core and system logic
  output var  logic              timer_pending_out,
  output var  logic              perf_pending_out,
  output var  logic              counter_stop_out,
  output var  logic [VOFS_W-1:0] interrupt_vector_offset_out,
  output var  logic [ADDR_W-1:0] exception_return_address_out
);

  // ----------------------------------------------------------------
  // Exception event carrier
  // ----------------------------------------------------------------
  exc_event_if ev ();

  // Drive the carrier from the pipeline ports
  assign ev.taken       = exc_taken_in;
  assign ev.in_slot     = exc_in_slot_in;
  assign ev.in_prologue = exc_in_prologue_in;
  assign ev.exc_level   = exception_level_bit_in;
  assign ev.fault_pc    = exc_fault_pc_in;
  assign ev.branch_pc   = exc_branch_pc_in;
  assign ev.cop_unit    = exc_cop_unit_in;

  logic             delay_slot_flag;
  logic             prologue_exception_flag;
  logic [COP_W-1:0] cop_unit_field;

  exc_capture u_capture (
    .sys_clk_in          (sys_clk_in),
    .reset_n_in          (reset_n_in),
    .ev                  (ev),
    .delay_slot_flag_out (delay_slot_flag),
    .prologue_flag_out   (prologue_exception_flag),
    .cop_unit_out        (cop_unit_field),
    .return_address_out  (exception_return_address_out)
  );

  // ----------------------------------------------------------------
  // Software-writable bits
  // ----------------------------------------------------------------
  logic counter_stop_bit;
  logic interrupt_vector_select;

  // Only the stop and vector-select bits take written data
  wire next_counter_stop_bit = reg_write_in ? reg_wdata_in[STOP_POS]
                                            : counter_stop_bit;
  wire next_vector_select    = reg_write_in ? reg_wdata_in[VSEL_POS]
                                            : interrupt_vector_select;

  // Vector offset chosen by the select bit
  wire [VOFS_W-1:0] next_vector_offset =
    next_vector_select ? INTERRUPT_VECTOR_OFFSET
                       : GENERAL_VECTOR_OFFSET;

  // Writable bit storage
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      counter_stop_bit        <= STOP_RESET;
      interrupt_vector_select <= VSEL_RESET;
    end else begin
      counter_stop_bit        <= next_counter_stop_bit;
      interrupt_vector_select <= next_vector_select;
    end
  end

  // Registered controls toward counter and dispatch logic
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      counter_stop_out            <= STOP_RESET;
      interrupt_vector_offset_out <= GENERAL_VECTOR_OFFSET;
    end else begin
      counter_stop_out            <= next_counter_stop_bit;
      interrupt_vector_offset_out <= next_vector_offset;
    end
  end

  // ----------------------------------------------------------------
  // Hardware-maintained flags
  // ----------------------------------------------------------------
  logic timer_pending_flag;
  logic perf_pending_flag;
  logic chaining_occurred_flag;

  // Pending flags follow their sources; writes never touch them
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      timer_pending_flag <= TIMER_RESET;
      perf_pending_flag  <= PERF_RESET;
    end else begin
      timer_pending_flag <= timer_irq_in;
      perf_pending_flag  <= perf_irq_in;
    end
  end

  // Pending outputs mirror the flags in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      timer_pending_out <= TIMER_RESET;
      perf_pending_out  <= PERF_RESET;
    end else begin
      timer_pending_out <= timer_irq_in;
      perf_pending_out  <= perf_irq_in;
    end
  end

  // Chaining result of the most recent interrupt return
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      chaining_occurred_flag <= CHAIN_RESET;
    end else if (int_return_done_in) begin
      chaining_occurred_flag <= int_return_chained_in;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] read_word;

  // Assemble the visible fields; lower bits belong elsewhere
  always_comb begin
    read_word                        = 32'h0000_0000;
    read_word[DELAY_SLOT_POS]        = delay_slot_flag;
    read_word[TIMER_POS]             = timer_pending_flag;
    read_word[COP_HI_POS:COP_LO_POS] = cop_unit_field;
    read_word[STOP_POS]              = counter_stop_bit;
    read_word[PERF_POS]              = perf_pending_flag;
    read_word[CHAIN_POS]             = chaining_occurred_flag;
    read_word[PROLOGUE_POS]          = prologue_exception_flag;
    read_word[VSEL_POS]              = interrupt_vector_select;
  end

  // Read data registered, one cycle behind the state
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= RDATA_RESET;
    end else begin
      reg_rdata_out <= read_word;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TIMER_READ: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    ##1 1'b1 |=> reg_rdata_out[TIMER_POS] == $past(timer_irq_in, 2))
    else $error("timer flag read wrong");

  AST_TIMER_PIN: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    $past(reset_n_in) |-> timer_pending_out == timer_pending_flag
      && timer_pending_out == $past(timer_irq_in))
    else $error("timer output differs from flag");

  AST_STOP_WRITE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_write_in |=> counter_stop_out == $past(reg_wdata_in[STOP_POS])
      ##1 reg_rdata_out[STOP_POS] == counter_stop_out || $past(reg_write_in))
    else $error("counter stop write not applied");

  AST_PERF_PIN: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    perf_irq_in |=> perf_pending_out && perf_pending_flag)
    else $error("perf pending not raised");

  AST_CHAIN: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    int_return_done_in |=>
      chaining_occurred_flag == $past(int_return_chained_in)
      ##1 reg_rdata_out[CHAIN_POS] == $past(chaining_occurred_flag))
    else $error("chaining flag wrong");

  AST_VSEL_OFFSET: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    interrupt_vector_offset_out == (interrupt_vector_select ?
      INTERRUPT_VECTOR_OFFSET : GENERAL_VECTOR_OFFSET))
    else $error("vector offset mismatch");

  AST_VSEL_WRITE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_write_in |=> interrupt_vector_select == $past(reg_wdata_in[VSEL_POS]))
    else $error("vector select write lost");

  AST_RO_WRITE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    (reg_write_in && !int_return_done_in && !exc_taken_in) |=>
      $stable(chaining_occurred_flag) && $stable(delay_slot_flag)
      && $stable(cop_unit_field) && $stable(prologue_exception_flag))
    else $error("write changed a read-only flag");

  COV_STOP: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) reg_write_in && reg_wdata_in[STOP_POS]);

  COV_VSEL: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    interrupt_vector_offset_out == INTERRUPT_VECTOR_OFFSET);

  COV_CHAIN: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) int_return_done_in && int_return_chained_in);

endmodule : exc_cause_status

`default_nettype wire

// ### sys_observer.sv
// System logic model that watches the core interrupt outputs
`timescale 1ns/1ns
`default_nettype none

module sys_observer (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       timer_pending_in,
  input  wire logic       perf_pending_in,
  output var  logic [7:0] timer_rises_out,
  output var  logic [7:0] perf_rises_out
);
  logic timer_last;
  logic perf_last;

  // ----------------------------------------------------------------
  // Edge counting
  // ----------------------------------------------------------------
  // Counts new pending levels as system logic would see them
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      timer_last      <= 1'h0;
      perf_last       <= 1'h0;
      timer_rises_out <= 8'h00;
      perf_rises_out  <= 8'h00;
    end else begin
      timer_last <= timer_pending_in;
      perf_last  <= perf_pending_in;
      if (timer_pending_in && !timer_last) begin
        timer_rises_out <= timer_rises_out + 8'h01;
      end
      if (perf_pending_in && !perf_last) begin
        perf_rises_out <= perf_rises_out + 8'h01;
      end
    end
  end
endmodule // sys_observer

`default_nettype wire

// ### testbench.sv
// Self-checking bench for the exception cause status block
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import exc_cause_pkg::*;

  localparam int MAX_CYCLES = 2000;

  logic        sys_clk_in = 1'h0;
  logic        reset_n_in = 1'h0;
  logic        reg_write_in = 1'h0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic [31:0] reg_rdata_out;
  logic        exc_taken_in = 1'h0;
  logic        exc_in_slot_in = 1'h0;
  logic        exc_in_prologue_in = 1'h0;
  logic        exception_level_bit_in = 1'h0;
  logic [31:0] exc_fault_pc_in = 32'h0000_0000;
  logic [31:0] exc_branch_pc_in = 32'h0000_0000;
  logic [1:0]  exc_cop_unit_in = 2'h0;
  logic        int_return_done_in = 1'h0;
  logic        int_return_chained_in = 1'h0;
  logic        timer_irq_in = 1'h0;
  logic        perf_irq_in = 1'h0;
  logic        timer_pending_out;
  logic        perf_pending_out;
  logic        counter_stop_out;
  logic [11:0] interrupt_vector_offset_out;
  logic [31:0] exception_return_address_out;
  logic [7:0]  timer_rises;
  logic [7:0]  perf_rises;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  logic        e_slot = 1'h0, e_tim = 1'h0, e_stop = 1'h0, e_perf = 1'h0;
  logic        e_chain = 1'h0, e_pro = 1'h0, e_vsel = 1'h0;
  logic [1:0]  e_cop = 2'h0;
  logic [31:0] e_ret = 32'h0000_0000;

  exc_cause_status i_exc_cause_status (
    .sys_clk_in                   (sys_clk_in),
    .reset_n_in                   (reset_n_in),
    .reg_write_in                 (reg_write_in),
    .reg_wdata_in                 (reg_wdata_in),
    .reg_rdata_out                (reg_rdata_out),
    .exc_taken_in                 (exc_taken_in),
    .exc_in_slot_in               (exc_in_slot_in),
    .exc_in_prologue_in           (exc_in_prologue_in),
    .exception_level_bit_in       (exception_level_bit_in),
    .exc_fault_pc_in              (exc_fault_pc_in),
    .exc_branch_pc_in             (exc_branch_pc_in),
    .exc_cop_unit_in              (exc_cop_unit_in),
    .int_return_done_in           (int_return_done_in),
    .int_return_chained_in        (int_return_chained_in),
    .timer_irq_in                 (timer_irq_in),
    .perf_irq_in                  (perf_irq_in),
    .timer_pending_out            (timer_pending_out),
    .perf_pending_out             (perf_pending_out),
    .counter_stop_out             (counter_stop_out),
    .interrupt_vector_offset_out  (interrupt_vector_offset_out),
    .exception_return_address_out (exception_return_address_out)
  );

  sys_observer i_sys_observer (
    .sys_clk_in       (sys_clk_in),
    .reset_n_in       (reset_n_in),
    .timer_pending_in (timer_pending_out),
    .perf_pending_in  (perf_pending_out),
    .timer_rises_out  (timer_rises),
    .perf_rises_out   (perf_rises)
  );

  // Clock and cycle ceiling
  always #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      num_errors++;
      $display("mismatch %0t run did not finish", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [31:0] exp_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[DELAY_SLOT_POS] = e_slot;
    w[TIMER_POS] = e_tim;
    w[COP_HI_POS:COP_LO_POS] = e_cop;
    w[STOP_POS] = e_stop;
    w[PERF_POS] = e_perf;
    w[CHAIN_POS] = e_chain;
    w[PROLOGUE_POS] = e_pro;
    w[VSEL_POS] = e_vsel;
    return w;
  endfunction

  // Ends pulses, checks outputs one cycle on and the word one more
  task automatic observe();
    logic [11:0] ofs;
    reg_write_in = 1'h0;
    exc_taken_in = 1'h0;
    int_return_done_in = 1'h0;
    ofs = e_vsel ? INTERRUPT_VECTOR_OFFSET : GENERAL_VECTOR_OFFSET;
    check({31'h0, counter_stop_out}, {31'h0, e_stop}, "stop");
    check({20'h0, interrupt_vector_offset_out}, {20'h0, ofs},
          "vec");
    check(exception_return_address_out, e_ret, "ret");
    check({31'h0, timer_pending_out}, {31'h0, e_tim}, "timer");
    check({31'h0, perf_pending_out}, {31'h0, e_perf}, "perf");
    @(negedge sys_clk_in);
    check(reg_rdata_out, exp_word(), "word");
  endtask

  task automatic wr(input logic [31:0] data);
    reg_write_in = 1'h1;
    reg_wdata_in = data;
    e_stop = data[STOP_POS];
    e_vsel = data[VSEL_POS];
    @(negedge sys_clk_in);
  endtask

  task automatic exc(input logic slot, pro, lvl, input logic [1:0] cop,
                     input logic [31:0] fault, branch);
    exc_taken_in = 1'h1;
    exc_in_slot_in = slot;
    exc_in_prologue_in = pro;
    exception_level_bit_in = lvl;
    exc_cop_unit_in = cop;
    exc_fault_pc_in = fault;
    exc_branch_pc_in = branch;
    e_cop = cop;
    e_pro = pro;
    if (!lvl) begin
      e_slot = slot;
      e_ret = slot ? branch : fault;
    end
    @(negedge sys_clk_in);
  endtask

  task automatic int_return(input logic chained);
    int_return_done_in = 1'h1;
    int_return_chained_in = chained;
    e_chain = chained;
    @(negedge sys_clk_in);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    observe();
  endtask

  task automatic t_irq();
    timer_irq_in = 1'h1;
    e_tim = 1'h1;
    @(negedge sys_clk_in);
    observe();
    perf_irq_in = 1'h1;
    e_perf = 1'h1;
    @(negedge sys_clk_in);
    observe();
    check({24'h0, timer_rises}, 32'h0000_0001, "seen timer");
    check({24'h0, perf_rises}, 32'h0000_0001, "seen perf");
  endtask

  task automatic t_exc();
    exc(1'h1, 1'h0, 1'h0, 2'h2, 32'h0000_1004, 32'h0000_1000);
    observe();
    exc(1'h0, 1'h1, 1'h1, 2'h1, 32'h0000_2000, 32'h0000_1FFC);
    observe();
    exc(1'h0, 1'h0, 1'h0, 2'h3, 32'h0000_3000, 32'h0000_2FFC);
    exc(1'h1, 1'h1, 1'h1, 2'h0, 32'h0000_4004, 32'h0000_4000);
    observe();
  endtask

  task automatic t_return();
    int_return(1'h1);
    observe();
    int_return(1'h0);
    observe();
    int_return(1'h0);
    int_return(1'h1);
    observe();
  endtask

  task automatic t_regs();
    wr(32'hFFFF_FFFF);
    observe();
    wr(32'h0080_0000);
    wr(32'h0800_0000);
    observe();
    wr(32'h0000_0000);
    observe();
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk_in);
    reset_n_in = 1'h1;
    @(negedge sys_clk_in);
    t_reset();
    t_irq();
    t_exc();
    t_return();
    t_regs();
    summarize();
  end
endmodule // testbench

`default_nettype wire
